// ---- hdl/cid_pkg.sv ----
// Shared constants and types for the identity and control register bank
package cid_pkg;
   // Register byte offsets
   localparam logic [14:0] ADR_VND_HI = 15'h0000;
   localparam logic [14:0] ADR_VND_LO = 15'h0001;
   localparam logic [14:0] ADR_PROD   = 15'h0002;
   localparam logic [14:0] ADR_REV    = 15'h0003;
   localparam logic [14:0] ADR_SER3   = 15'h0004;
   localparam logic [14:0] ADR_SER2   = 15'h0005;
   localparam logic [14:0] ADR_SER1   = 15'h0006;
   localparam logic [14:0] ADR_SER0   = 15'h0007;
   localparam logic [14:0] ADR_SOFTC  = 15'h0008;
   localparam logic [14:0] ADR_HARDC  = 15'h0009;
   localparam logic [14:0] ADR_BUSADR = 15'h000A;
   localparam logic [14:0] ADR_NVREV  = 15'h000B;
   localparam logic [14:0] ADR_CTL    = 15'h000C;
   localparam logic [14:0] ADR_STSRC  = 15'h000D;
   localparam logic [14:0] ADR_STLP1  = 15'h000E;
   // Device control bit positions and write mask
   localparam int          CTL_SRST   = 7;
   localparam int          CTL_SYNC   = 6;
   localparam int          CTL_ASYNC  = 4;
   localparam int          CTL_MUTE   = 3;
   localparam int          CTL_CALORD = 1;
   localparam int          CTL_AUTOST = 0;
   localparam logic [7:0]  CTL_RST    = 8'h00;
   localparam logic [7:0]  CTL_WMASK  = 8'h7B;
   // Tri-level strap codes and operating configurations
   localparam logic [1:0]  LVL_LOW    = 2'h0;
   localparam logic [1:0]  LVL_HIGH   = 2'h1;
   localparam logic [1:0]  LVL_MID    = 2'h2;
   localparam logic [2:0]  OPM_NV_SPI = 3'h0;
   localparam logic [2:0]  OPM_TEST   = 3'h1;
   localparam logic [2:0]  OPM_NV_I2C = 3'h2;
   localparam logic [2:0]  OPM_ROM    = 3'h3;
   // Timing and framing
   localparam int          CLK_MHZ    = 100;
   localparam int          SETTLE_NS  = 80;
   localparam int          SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int          ASYNC_NS   = 100;
   localparam int          ASYNC_CYC  = ASYNC_NS * CLK_MHZ / 1000;
   localparam logic [4:0]  HDR_LAST   = 5'h0F;
   localparam logic [4:0]  FRM_LAST   = 5'h17;
   localparam logic [4:0]  FRM_BITS   = 5'h18;
   typedef enum logic [2:0] {
      RUN_CFG  = 3'h1,
      RUN_HALT = 3'h2,
      RUN_GO   = 3'h4
   } cid_run_t;
endpackage

// ---- hdl/cid_reg_if.sv ----
// Internal register access channel between serial engine and bank
`timescale 1ns/1ps
interface cid_reg_if;
   logic [14:0] addr;
   logic [7:0]  wdata;
   logic        wr;
   logic [7:0]  rdata;
   modport link (output addr, output wdata, output wr, input rdata);
   modport regs (input addr, input wdata, input wr, output rdata);
endinterface // cid_reg_if

// ---- hdl/cid_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module cid_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Raw and filtered levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } cid_sync_st_t;
   cid_sync_st_t st_ff, nxt_st;

   // Output moves only when stages two and three agree
   always_comb
   begin
      nxt_st    = st_ff;
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      nxt_st.q  = (~(st_ff.s2 ^ st_ff.s3) & st_ff.s3)
                | ((st_ff.s2 ^ st_ff.s3) & st_ff.q);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign q = st_ff.q;
endmodule // cid_sync

// ---- hdl/cid_spi.sv ----
// Serial host port engine: 24-bit frames, rw bit, 15-bit address, data
`timescale 1ns/1ps
module cid_spi (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Serial pins
   input  wire logic spi_sclk,
   input  wire logic spi_cs_n,
   input  wire logic spi_mosi,
   output logic      spi_miso,
   output logic      spi_miso_oe,
   // Register channel
   cid_reg_if.link   rb
);
   typedef struct packed {
      logic [4:0]  cnt;
      logic [22:0] sh;
      logic [14:0] addr;
      logic        rd;
      logic        ld;
      logic        wr;
      logic [7:0]  wdata;
      logic [7:0]  sout;
      logic        sclk_q;
   } cid_spi_st_t;
   cid_spi_st_t st_ff, nxt_st;
   logic [2:0]  pins;
   logic        rise;

   // Select enters inverted so a cleared filter reads as deselected
   // and the shared data line is not driven just after reset
   cid_sync #(.W(3)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({~spi_cs_n, spi_sclk, spi_mosi}),
      .q     (pins)
   );

   assign rise = pins[1] & ~st_ff.sclk_q;

   // Shift in on rising edges; read data goes out MSB first
   always_comb
   begin
      nxt_st        = st_ff;
      nxt_st.sclk_q = pins[1];
      nxt_st.ld     = 1'b0;
      nxt_st.wr     = 1'b0;
      if (st_ff.ld)
         nxt_st.sout = st_ff.rd ? rb.rdata : 8'h00;
      if (!pins[2])
         nxt_st.cnt = 5'h00;
      else if (rise && st_ff.cnt != cid_pkg::FRM_BITS)
      begin
         nxt_st.sh  = {st_ff.sh[21:0], pins[0]};
         nxt_st.cnt = st_ff.cnt + 5'h01;
         if (st_ff.cnt > cid_pkg::HDR_LAST)
            nxt_st.sout = {st_ff.sout[6:0], 1'b0};
         if (st_ff.cnt == cid_pkg::HDR_LAST)
         begin
            nxt_st.addr = {st_ff.sh[13:0], pins[0]};
            nxt_st.rd   = st_ff.sh[14];
            nxt_st.ld   = 1'b1;
         end
         if (st_ff.cnt == cid_pkg::FRM_LAST && !st_ff.rd)
         begin
            nxt_st.wdata = {st_ff.sh[6:0], pins[0]};
            nxt_st.wr    = 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign rb.addr     = st_ff.addr;
   assign rb.wdata    = st_ff.wdata;
   assign rb.wr       = st_ff.wr;
   assign spi_miso    = st_ff.sout[7];
   assign spi_miso_oe = pins[2];
endmodule // cid_spi

// ---- hdl/cid_top.sv ----
// Identity, strap capture, device control and live status register bank
//
// Contract
// - Vendor code reads as two bytes, upper byte at offset zero.
// - Product code byte is read-only.
// - Silicon revision byte is read-only, all eight bits.
// - Serial number over four bytes, MSB first, never writable.
// - Bit 6 holds control pin level caught at power-on reset.
// - Bits 5:4 hold pin 2 level when control not high, else zero.
// - Bit 3 set when pin 2 floated and control pin low.
// - Bits 2:0 give operating configuration decoded from three pins.
// - Bits 3:0 hold pins 3..0 when control pin high, bit 4 zero.
// - Bus address bits 7:1: stored base, then pin-derived low bits.
// - Image revision reloads after every reset and every commit.
// - Control bit 7 restarts device, keeps control and captures, reloads image revision.
// - Control bit 6 drives output sync directly; resets to zero.
// - Control bit 4 fires sync automatically on analog lock.
// - Control bit 3 mutes outputs during sync.
// - Bit 1 clear: second loop calibrates after first locks or off.
// - Bit 0 starts up after reset; else halt until host sets it.
// - Live source status byte, no latching.
// - Loop one phase and frequency unlock in bits 7 and 6.
// - Loop one event bits 5..0 shown live.
`timescale 1ns/1ps
module cid_top #(
   parameter logic [15:0] VENDOR_CODE  = 16'h5A5A, // Arbitrary value
   parameter logic [7:0]  PRODUCT_CODE = 8'hA5,    // Arbitrary value
   parameter logic [7:0]  SILICON_REV  = 8'h01     // Arbitrary value
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Host serial port
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_mosi,
   output logic             spi_miso,
   output logic             spi_miso_oe,
   // Strap pins
   input  wire logic [1:0]  config_source_pin,
   input  wire logic [1:0]  stat0_lvl,
   input  wire logic [1:0]  stat1_lvl,
   input  wire logic [1:0]  gpio2_lvl,
   input  wire logic        gpio1_pin,
   input  wire logic [3:0]  gpio_hw_pins,
   input  wire logic        power_down_pin,
   // Nonvolatile store
   input  wire logic [31:0] serial_number,
   input  wire logic [4:0]  nvm_base_addr,
   input  wire logic [7:0]  nvm_image_revision,
   input  wire logic        nvm_commit_done,
   // Analog and loop status
   input  wire logic [5:0]  src_alarm,
   input  wire logic [7:0]  loop1_alarm,
   input  wire logic        pll1_powered_down,
   // Device actions
   output logic             out_sync,
   output logic             out_mute,
   output logic             pll2_cal_en,
   output logic             startup_go,
   output logic             startup_run,
   output logic             soft_reset_pulse
);
   typedef struct packed {
      cid_pkg::cid_run_t run;
      logic [3:0]        settle;
      logic              capd;
      logic [6:0]        scap;
      logic [4:0]        hcap;
      logic [1:0]        alsb;
      logic [7:0]        rev;
      logic [7:0]        ctl;
      logic              srst;
      logic              go;
      logic [3:0]        acnt;
      logic              lock_q;
   } cid_st_t;
   cid_st_t st_ff, nxt_st;

   cid_reg_if  rb ();
   logic [28:0] sy;
   logic [1:0]  s_ctl, s_st0, s_st1, s_g2;
   logic        s_g1, s_pwrdn, s_p1off, locked;
   logic [3:0]  s_ghw;
   logic [5:0]  s_src;
   logic [7:0]  s_lp1;
   logic        ctl_wr;

   ////////////////////////////////////////////////////////////////////
   // Host port and pin synchronisers

   cid_spi u_spi (
      .clk         (clk),
      .rst_n       (rst_n),
      .spi_sclk    (spi_sclk),
      .spi_cs_n    (spi_cs_n),
      .spi_mosi    (spi_mosi),
      .spi_miso    (spi_miso),
      .spi_miso_oe (spi_miso_oe),
      .rb          (rb.link)
   );

   cid_sync #(.W(29)) u_pins (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({pll1_powered_down, loop1_alarm, src_alarm,
               power_down_pin, gpio_hw_pins, gpio1_pin, gpio2_lvl,
               stat1_lvl, stat0_lvl, config_source_pin}),
      .q     (sy)
   );

   // Named slices of the filtered pins
   assign s_ctl   = sy[1:0];
   assign s_st0   = sy[3:2];
   assign s_st1   = sy[5:4];
   assign s_g2    = sy[7:6];
   assign s_g1    = sy[8];
   assign s_ghw   = sy[12:9];
   assign s_pwrdn = sy[13];
   assign s_src   = sy[19:14];
   assign s_lp1   = sy[27:20];
   assign s_p1off = sy[28];
   assign locked  = ~|s_src[3:2];
   assign ctl_wr  = rb.wr && rb.addr == cid_pkg::ADR_CTL;

   ////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.srst = 1'b0;
      nxt_st.go   = 1'b0;
      nxt_st.lock_q = locked;
      // Straps held off until the filters have settled
      if (!st_ff.capd)
      begin
         nxt_st.settle = st_ff.settle + 4'h1;
         if (st_ff.settle == 4'(cid_pkg::SETTLE_CYC - 1))
         begin
            nxt_st.capd = 1'b1;
            nxt_st.scap[6] = s_ctl == cid_pkg::LVL_HIGH;
            nxt_st.scap[5:4] = (s_ctl == cid_pkg::LVL_HIGH)
                             ? 2'h0 : s_g2;
            nxt_st.scap[3] = s_ctl == cid_pkg::LVL_LOW
                           && s_g2 == cid_pkg::LVL_MID;
            if (s_ctl == cid_pkg::LVL_HIGH)
               nxt_st.scap[2:0] = cid_pkg::OPM_ROM;
            else if (s_ctl == cid_pkg::LVL_LOW)
               nxt_st.scap[2:0] = cid_pkg::OPM_NV_I2C;
            else if (s_st0 == cid_pkg::LVL_MID
                     && s_st1 == cid_pkg::LVL_MID)
               nxt_st.scap[2:0] = cid_pkg::OPM_NV_SPI;
            else
               nxt_st.scap[2:0] = cid_pkg::OPM_TEST;
            nxt_st.hcap = (s_ctl == cid_pkg::LVL_HIGH)
                        ? {1'b0, s_ghw} : 5'h00;
            nxt_st.alsb = (s_ctl == cid_pkg::LVL_HIGH)
                        ? 2'h0
                        : {s_g2 == cid_pkg::LVL_HIGH, s_g1};
         end
      end
      // Image revision reload on reset end, soft reset, commit
      if ((!st_ff.capd && st_ff.settle == 4'(cid_pkg::SETTLE_CYC - 1))
          || st_ff.srst || nvm_commit_done)
         nxt_st.rev = nvm_image_revision;
      // Only writable control bits are stored
      if (ctl_wr)
      begin
         nxt_st.ctl = (st_ff.ctl & ~cid_pkg::CTL_WMASK)
                    | (rb.wdata & cid_pkg::CTL_WMASK);
         nxt_st.srst = rb.wdata[cid_pkg::CTL_SRST];
      end
      // Auto sync window opens on the rising edge of lock
      if (locked && !st_ff.lock_q && st_ff.ctl[cid_pkg::CTL_ASYNC])
         nxt_st.acnt = 4'(cid_pkg::ASYNC_CYC);
      else if (st_ff.acnt != 4'h0)
         nxt_st.acnt = st_ff.acnt - 4'h1;
      // Start-up sequencing
      if (st_ff.srst || s_pwrdn)
         nxt_st.run = cid_pkg::RUN_CFG;
      else
      begin
         unique case (st_ff.run)
            cid_pkg::RUN_CFG:
               if (st_ff.capd)
               begin
                  if (st_ff.ctl[cid_pkg::CTL_AUTOST])
                  begin
                     nxt_st.run = cid_pkg::RUN_GO;
                     nxt_st.go  = 1'b1;
                  end
                  else
                     nxt_st.run = cid_pkg::RUN_HALT;
               end
            cid_pkg::RUN_HALT:
               if (st_ff.ctl[cid_pkg::CTL_AUTOST])
               begin
                  nxt_st.run = cid_pkg::RUN_GO;
                  nxt_st.go  = 1'b1;
               end
            cid_pkg::RUN_GO:
               nxt_st.run = cid_pkg::RUN_GO;
            default:
               nxt_st.run = cid_pkg::RUN_CFG;
         endcase
      end
   end

   // State register; captures survive a soft reset by design
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_ff      <= '0;
         st_ff.run  <= cid_pkg::RUN_CFG;
         st_ff.ctl  <= cid_pkg::CTL_RST;
      end
      else
         st_ff <= nxt_st;
   end

   ////////////////////////////////////////////////////////////////////
   // Register read decode; unmapped offsets read zero

   always_comb
   begin
      rb.rdata = 8'h00;
      unique case (rb.addr)
         cid_pkg::ADR_VND_HI: rb.rdata = VENDOR_CODE[15:8];
         cid_pkg::ADR_VND_LO: rb.rdata = VENDOR_CODE[7:0];
         cid_pkg::ADR_PROD:   rb.rdata = PRODUCT_CODE;
         cid_pkg::ADR_REV:    rb.rdata = SILICON_REV;
         cid_pkg::ADR_SER3:   rb.rdata = serial_number[31:24];
         cid_pkg::ADR_SER2:   rb.rdata = serial_number[23:16];
         cid_pkg::ADR_SER1:   rb.rdata = serial_number[15:8];
         cid_pkg::ADR_SER0:   rb.rdata = serial_number[7:0];
         cid_pkg::ADR_SOFTC:  rb.rdata = {1'b0, st_ff.scap};
         cid_pkg::ADR_HARDC:  rb.rdata = {3'h0, st_ff.hcap};
         cid_pkg::ADR_BUSADR:
            rb.rdata = {nvm_base_addr, st_ff.alsb, 1'b0};
         cid_pkg::ADR_NVREV:  rb.rdata = st_ff.rev;
         cid_pkg::ADR_CTL:    rb.rdata = st_ff.ctl;
         cid_pkg::ADR_STSRC:  rb.rdata = {2'h0, s_src};
         cid_pkg::ADR_STLP1:  rb.rdata = s_lp1;
         default:             rb.rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Device action outputs

   // Sync follows the host bit or the auto window
   assign out_sync = st_ff.ctl[cid_pkg::CTL_SYNC]
                   | (st_ff.acnt != 4'h0);
   assign out_mute = out_sync
                   & st_ff.ctl[cid_pkg::CTL_MUTE];
   // Unless bit 1 is set, second loop waits for first loop lock or power-down
   assign pll2_cal_en = (st_ff.run == cid_pkg::RUN_GO)
                      & (st_ff.ctl[cid_pkg::CTL_CALORD]
                         | ~s_src[2] | s_p1off);
   assign startup_go       = st_ff.go;
   assign startup_run      = st_ff.run == cid_pkg::RUN_GO;
   assign soft_reset_pulse = st_ff.srst;

   ////////////////////////////////////////////////////////////////////
   // Checks

   a_srst_pulse: assert property (
      @(posedge clk) disable iff (!rst_n)
      ctl_wr && rb.wdata[7] |=> soft_reset_pulse ##1
      (st_ff.run == cid_pkg::RUN_CFG))
      else $error("soft reset did not restart sequencing");

   a_sync_direct: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_ff.ctl[cid_pkg::CTL_SYNC] |-> out_sync)
      else $error("sync bit set but sync not asserted");

   a_auto_sync: assert property (
      @(posedge clk) disable iff (!rst_n)
      locked && !st_ff.lock_q && st_ff.ctl[cid_pkg::CTL_ASYNC]
      |=> out_sync [*8])
      else $error("auto sync window too short");

   a_mute_gate: assert property (
      @(posedge clk) disable iff (!rst_n)
      out_mute == (out_sync && st_ff.ctl[3]))
      else $error("mute does not track sync and mute bit");

   a_cal_wait: assert property (
      @(posedge clk) disable iff (!rst_n)
      !st_ff.ctl[1] && s_src[2] && !s_p1off |-> !pll2_cal_en)
      else $error("second loop calibrating before first lock");

   a_auto_start: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_ff.run == cid_pkg::RUN_CFG && st_ff.capd && st_ff.ctl[0]
      && !s_pwrdn && !st_ff.srst |=> startup_go ##1 startup_run)
      else $error("autostart did not launch start-up");

   a_halt_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_ff.run == cid_pkg::RUN_HALT && !st_ff.ctl[0]
      |-> !startup_run && !startup_go)
      else $error("start-up ran while halted");

   a_strap_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_ff.capd && $past(st_ff.capd) |-> $stable(st_ff.scap)
      && $stable(st_ff.hcap))
      else $error("strap capture changed after power-on");

   a_pin2_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_ff.scap[6] |-> st_ff.scap[5:3] == 3'h0
      && st_ff.scap[2:0] == cid_pkg::OPM_ROM)
      else $error("soft fields set in hard pin mode");

   a_rev_load: assert property (
      @(posedge clk) disable iff (!rst_n)
      nvm_commit_done |=> st_ff.rev == $past(nvm_image_revision))
      else $error("image revision not reloaded on commit");

endmodule // cid_top

// ---- testbench/cid_host.sv ----
// Host model driving the serial register port of the bank
`timescale 1ns/1ps
module cid_host (
   // Serial pins
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe
);
   ////////////////////////////////////////////////////////////////////////
   // Idle levels: clock stands low, select released
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // One 24-bit frame at 125 ns bit time, read byte caught before edges
   // 17 to 24 so the slow synchronised shifter has settled
   task automatic xfer(input logic rd, input logic [14:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      logic [23:0] f;
      #3;            // Keep every pin change clear of the sampling edge
      f = {rd, a, d};
      q = 8'h00;
      cs_n = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         mosi = f[i];
         #62.5;
         if (i < 8)
            q[i] = miso;
         sclk = 1'b1;
         #62.5;
         sclk = 1'b0;
      end
      #62.5;
      cs_n = 1'b1;
      mosi = ~mosi;  // Released line must not keep last value
      #97;           // Select high well over 4 clocks; keeps bit phase
   endtask
endmodule // cid_host

// ---- testbench/tb_cid_top.sv ----
// Self-checking bench for the identity and control register bank
`timescale 1ns/1ps
module tb_cid_top;
   localparam logic [15:0] VND = 16'hC3E1; // Arbitrary value
   localparam logic [7:0]  PRD = 8'h6D;    // Arbitrary value
   localparam logic [7:0]  REV = 8'h2B;    // Arbitrary value
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sclk, cs_n, mosi, miso, miso_oe;
   logic [1:0]  cfg_p = 2'h0, st0 = 2'h0, st1 = 2'h0, g2_p = 2'h0;
   logic        g1_p = 1'b0, p1off = 1'b0, pd_pin = 1'b0, commit = 1'b0;
   logic [3:0]  hw_p = 4'h0;
   logic [31:0] ser = 32'h0;
   logic [4:0]  base = 5'h18;
   logic [7:0]  nvrev = 8'h00, l1a = 8'h00;
   logic [5:0]  src = 6'h00;
   logic        sync_o, mute_o, cal_o, go_o, run_o, srst_o;
   int          fail_count = 0, comparisons = 0;
   int          go_cnt = 0, srst_cnt = 0, sync_cnt = 0;

   always #5 clk = ~clk;

   cid_top #(.VENDOR_CODE(VND), .PRODUCT_CODE(PRD), .SILICON_REV(REV)) dut (
      .clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
      .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
      .config_source_pin(cfg_p), .stat0_lvl(st0), .stat1_lvl(st1),
      .gpio2_lvl(g2_p), .gpio1_pin(g1_p), .gpio_hw_pins(hw_p),
      .power_down_pin(pd_pin), .serial_number(ser), .nvm_base_addr(base),
      .nvm_image_revision(nvrev), .nvm_commit_done(commit),
      .src_alarm(src), .loop1_alarm(l1a), .pll1_powered_down(p1off),
      .out_sync(sync_o), .out_mute(mute_o), .pll2_cal_en(cal_o),
      .startup_go(go_o), .startup_run(run_o), .soft_reset_pulse(srst_o));

   cid_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
                  .miso_oe(miso_oe));

   ////////////////////////////////////////////////////////////////////////
   // Pulse and level counters, so one-cycle events are never missed
   always @(posedge clk)
   begin
      go_cnt   <= go_cnt + int'(go_o === 1'b1);
      srst_cnt <= srst_cnt + int'(srst_o === 1'b1);
      sync_cnt <= sync_cnt + int'(sync_o === 1'b1);
   end

   // Expected strap captures
   function automatic logic [7:0] exp_soft(logic [1:0] c, s0, s1, g);
      logic [2:0] op;
      logic       hi;
      hi = (c == cid_pkg::LVL_HIGH);
      op = (c == cid_pkg::LVL_LOW) ? cid_pkg::OPM_NV_I2C :
           hi ? cid_pkg::OPM_ROM :
           (s0 == cid_pkg::LVL_MID && s1 == cid_pkg::LVL_MID) ?
           cid_pkg::OPM_NV_SPI : cid_pkg::OPM_TEST;
      return {1'b0, hi, hi ? 2'h0 : g,
              g == cid_pkg::LVL_MID && c == cid_pkg::LVL_LOW, op};
   endfunction
   function automatic logic [7:0] exp_hard(logic [1:0] c, logic [3:0] p);
      return (c == cid_pkg::LVL_HIGH) ? {4'h0, p} : 8'h00;
   endfunction
   function automatic logic [7:0] exp_adr(logic [1:0] c, g, logic g1,
                                          logic [4:0] b);
      return {b, (c == cid_pkg::LVL_HIGH) ? 2'b00 :
              {g == cid_pkg::LVL_HIGH, g1}, 1'b0};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Shared checks and port cycles
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      logic [7:0] q;
      host.xfer(1'b1, a, 8'h00, q);
      chk(q, e);
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] q;
      host.xfer(1'b0, a, d, q);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic end_sim;
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Hang guard
   initial
   begin
      #500000;
      fail_count++;
      end_sim;
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      logic [1:0]  c, a, b, g;
      logic [7:0]  q, e;
      logic [63:0] idv;
      int          s;
      s = $urandom(32'h17e3a783);
      // Every operating configuration, each behind a fresh reset
      for (int k = 0; k < 4; k++)
      begin
         c = (k > 2) ? cid_pkg::LVL_MID : 2'(k);
         a = (k == 3) ? cid_pkg::LVL_MID : 2'($urandom_range(1, 0));
         b = (k == 3) ? cid_pkg::LVL_MID : 2'($urandom_range(1, 0));
         g = 2'($urandom_range(2, 0));
         @(posedge clk);
         rst_n <= 1'b0;
         cfg_p <= c;
         st0 <= a;
         st1 <= b;
         g2_p <= g;
         g1_p <= 1'($urandom);
         hw_p <= 4'($urandom);
         base <= 5'($urandom);
         nvrev <= 8'($urandom);
         ser <= $urandom;
         tick(8);
         rst_n <= 1'b1;
         tick(30);
         e = exp_soft(c, a, b, g);
         rd(cid_pkg::ADR_SOFTC, e);
         rd(cid_pkg::ADR_HARDC, exp_hard(c, hw_p));
         host.xfer(1'b1, cid_pkg::ADR_BUSADR, 8'h00, q);
         chk({q[7:1], 1'b0}, exp_adr(c, g, g1_p, base));
         rd(cid_pkg::ADR_NVREV, nvrev);
      end
      // Identity bytes survive writes; unmapped reads give zero
      idv = {VND, PRD, REV, ser};
      for (int i = 0; i < 8; i++)
      begin
         e = idv[63 - 8 * i -: 8];
         wr(15'(i), ~e);
         rd(15'(i), e);
      end
      rd(15'h000F, 8'h00);
      rd(15'h7FFF, 8'h00);
      // Commit reloads the image revision
      @(posedge clk);
      nvrev <= ~nvrev;
      commit <= 1'b1;
      @(posedge clk);
      commit <= 1'b0;
      rd(cid_pkg::ADR_NVREV, nvrev);
      // Control: sync, mute, start from halt, stored bits only
      e = exp_soft(c, a, b, g);
      wr(cid_pkg::ADR_CTL, 8'h6D);
      tick(4);
      chk({5'h00, miso_oe, sync_o, mute_o}, 8'h03);
      rd(cid_pkg::ADR_CTL, 8'h6D & cid_pkg::CTL_WMASK);
      chk({run_o, 7'(go_cnt)}, 8'h81);
      // Soft reset keeps captures and restarts with autostart set
      wr(cid_pkg::ADR_CTL, 8'h81);
      tick(20);
      chk({7'(srst_cnt), sync_o}, 8'h02);
      chk(8'(go_cnt), 8'h02);
      rd(cid_pkg::ADR_CTL, 8'h01);
      rd(cid_pkg::ADR_SOFTC, e);
      // Power-down pin holds start-up in configuration until released
      @(posedge clk);
      pd_pin <= 1'b1;
      tick(10);
      chk({run_o, 7'(go_cnt)}, 8'h02);
      pd_pin <= 1'b0;
      tick(10);
      chk({run_o, 7'(go_cnt)}, 8'h83);
      // Second loop waits while first loop unlocked; power-down or bit 1 releases it
      for (int m = 0; m < 3; m++)
      begin
         @(posedge clk);
         src <= 6'h04;
         p1off <= (m == 1);
         if (m == 2)
            wr(cid_pkg::ADR_CTL, 8'h03);
         tick(10);
         chk({7'h00, cal_o}, {7'h00, 1'(m != 0)});
      end
      // Automatic sync window on lock, only with its enable set
      for (int m = 1; m >= 0; m--)
      begin
         wr(cid_pkg::ADR_CTL, (m != 0) ? 8'h13 : 8'h03);
         @(posedge clk);
         src <= 6'h0C;
         tick(20);
         s = sync_cnt;
         src <= 6'h00;
         tick(40);
         e = (m != 0) ? 8'(cid_pkg::ASYNC_CYC) : 8'h00;
         chk(8'(sync_cnt - s), e);
      end
      // Live status follows the inputs
      repeat (4)
      begin
         @(posedge clk);
         src <= 6'($urandom);
         l1a <= 8'($urandom);
         tick(8);
         rd(cid_pkg::ADR_STSRC, {2'b00, src});
         rd(cid_pkg::ADR_STLP1, l1a);
      end
      end_sim;
   end
endmodule // tb_cid_top
